// [accr_map.vh]
// Register map constants for the channel calibration register group
// Contract
// (RULE1) Config bits 15:6 hold a signed ten-bit phase delay in modulator cycles.
// (RULE2) Config bits 5:3 ignore writes and read as zero.
// (RULE3) Config bit 2 set bypasses the global high-pass for this channel; resets clear.
// (RULE4) Config bits 1:0 select own pins, shorted, positive or negative test level.
// (RULE5) Offset is 24-bit signed; bits 23:8 fill the whole high offset word.
// (RULE6) Offset bits 7:0 sit in low word bits 15:8; bits 7:0 read zero.
// (RULE7) Gain is 24-bit unsigned; 23:8 in high word, 7:0 in low word upper byte.
// (RULE8) Gain maps linearly to 0.0 up to below 2.0; high word resets to 8000h.
// (RULE9) Global 4-bit high-pass setting in threshold low word nibble applies to enabled channels.
// (RULE10) Samples get offset added and gain multiplied, using full 24-bit values.
`ifndef ACCR_MAP_VH
`define ACCR_MAP_VH
`define ACCR_IDX_THRESH_LOW   8'h08
`define ACCR_IDX_CHAN0_CONFIG 8'h09
`define ACCR_IDX_CHAN0_OFFH   8'h0a
`define ACCR_IDX_CHAN0_OFFL   8'h0b
`define ACCR_IDX_CHAN0_GAINH  8'h0c
`define ACCR_IDX_CHAN0_GAINL  8'h0d
`define ACCR_IDX_CHAN1_CONFIG 8'h0e
`define ACCR_RST_CONFIG       16'h0000
`define ACCR_RST_OFFSET       16'h0000
`define ACCR_RST_GAIN_HIGH    16'h8000
`define ACCR_RST_GAIN_LOW     16'h0000
`define ACCR_RST_THRESH_LOW   16'h0000
`define ACCR_CFG_WMASK        16'hffc7
`define ACCR_LOW_WMASK        16'hff00
`define ACCR_THR_WMASK        16'hff0f
`define ACCR_CFG_PHASE_HI     15
`define ACCR_CFG_PHASE_LO     6
`define ACCR_CFG_BYPASS_BIT   2
`define ACCR_SEL_OWN_PINS     2'h0
`define ACCR_SEL_SHORTED      2'h1
`define ACCR_SEL_TEST_POS     2'h2
`define ACCR_SEL_TEST_NEG     2'h3
`endif

// [accr_word_reg.v]
// One 16-bit register word with write mask and reset value
`timescale 1ns/1ps
module accr_word_reg #(
  parameter [15:0] RST_VAL = 16'h0000,
  parameter [15:0] WMASK   = 16'hffff
) (
  input  wire        clk_sys_i,
  input  wire        sys_rst_i,
  input  wire        wr_en_i,
  input  wire [15:0] wr_data_i,
  output wire [15:0] value_o
);
  reg [15:0] word_reg;
  // Masked bits never store, so reserved bits stay zero
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      word_reg <= RST_VAL;
    end else if (wr_en_i) begin
      word_reg <= (wr_data_i & WMASK) | (word_reg & ~WMASK);
    end
  end
  assign value_o = word_reg;
endmodule // accr_word_reg

// [accr_sample_corr.v]
// Offset and gain correction of one 24-bit sample
`timescale 1ns/1ps
module accr_sample_corr (
  input  wire        clk_sys_i,
  input  wire        sys_rst_i,
  input  wire        valid_i,
  input  wire [23:0] sample_i,
  input  wire [23:0] offset_i,
  input  wire [23:0] gain_i,
  output reg         valid_o,
  output reg  [23:0] sample_o
);
  // Saturate a 26-bit signed value to 24 bits
  function [23:0] sat24;
    input [25:0] v;
    begin
      if (!v[25] && (v[24] | v[23]))
        sat24 = 24'h7fffff;
      else if (v[25] && !(v[24] & v[23]))
        sat24 = 24'h800000;
      else
        sat24 = v[23:0];
    end
  endfunction
  wire signed [24:0] sum_w  = $signed({sample_i[23], sample_i}) + $signed({offset_i[23], offset_i});
  reg  signed [24:0] sum_reg;
  reg                mid_valid_reg;
  reg         [23:0] gain_reg;
  // Gain code 800000h is unity: product shifted by 23 bits
  wire signed [49:0] prod_w = sum_reg * $signed({1'b0, gain_reg});
  wire        [25:0] scaled_w = prod_w[48:23];
  // Two stages: add, then multiply, to keep the multiplier path short
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sum_reg       <= 25'h0000000;
      mid_valid_reg <= 1'b0;
      gain_reg      <= 24'h000000;
      valid_o       <= 1'b0;
      sample_o      <= 24'h000000;
    end else begin
      sum_reg       <= sum_w;              // [RULE10]
      gain_reg      <= gain_i;
      mid_valid_reg <= valid_i;
      valid_o       <= mid_valid_reg;
      sample_o      <= sat24(scaled_w);    // [RULE10] [RULE8]
    end
  end
endmodule // accr_sample_corr

// [accr_chan_regs.v]
// APB register group for channel calibration and configuration
`timescale 1ns/1ps
`include "accr_map.vh"
module accr_chan_regs (
  input  wire        clk_sys_i,
  input  wire        sys_rst_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [31:0] paddr_i,
  input  wire [31:0] pwdata_i,
  input  wire [3:0]  pstrb_i,
  output reg         pready_o,
  output reg  [31:0] prdata_o,
  output reg         pslverr_o,
  input  wire        sample_valid_i,
  input  wire [23:0] sample_i,
  output reg         sample_valid_o,
  output reg  [23:0] sample_o,
  output reg  [9:0]  chan0_phase_delay_o,
  output reg         chan0_highpass_bypass_o,
  output reg  [1:0]  chan0_input_select_o,
  output reg  [3:0]  chan0_highpass_setting_o,
  output reg         chan0_highpass_active_o,
  output reg  [9:0]  chan1_phase_delay_o,
  output reg  [1:0]  chan1_input_select_o,
  output reg  [3:0]  chan1_highpass_setting_o,
  output reg         chan1_highpass_active_o
);
  // Word index decode; byte address is four times the index
  function hit;
    input [31:0] addr;
    input [7:0]  idx;
    begin
      hit = (addr[31:10] == 22'h000000) && (addr[9:2] == idx) && (addr[1:0] == 2'h0);
    end
  endfunction

  wire        setup_w  = psel_i && !penable_i;
  wire        wr_go_w  = setup_w && pwrite_i && (pstrb_i[1:0] == 2'h3);
  wire [15:0] wdata_w  = pwdata_i[15:0];
  wire [15:0] thr_w;
  wire [15:0] cfg0_w;
  wire [15:0] offh_w;
  wire [15:0] offl_w;
  wire [15:0] gainh_w;
  wire [15:0] gainl_w;
  wire [15:0] cfg1_w;
  wire        corr_valid_w;
  wire [23:0] corr_sample_w;

  // Threshold low word: only the high-pass nibble acts here
  accr_word_reg #(.RST_VAL(`ACCR_RST_THRESH_LOW), .WMASK(`ACCR_THR_WMASK)) u_thr (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .wr_en_i   (wr_go_w && hit(paddr_i, `ACCR_IDX_THRESH_LOW)),
    .wr_data_i (wdata_w),
    .value_o   (thr_w)
  );
  // Config bits 5:3 masked off so they read zero
  accr_word_reg #(.RST_VAL(`ACCR_RST_CONFIG), .WMASK(`ACCR_CFG_WMASK)) u_cfg0 (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .wr_en_i   (wr_go_w && hit(paddr_i, `ACCR_IDX_CHAN0_CONFIG)), // [RULE2]
    .wr_data_i (wdata_w),
    .value_o   (cfg0_w)
  );
  accr_word_reg #(.RST_VAL(`ACCR_RST_OFFSET), .WMASK(16'hffff)) u_offh (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .wr_en_i   (wr_go_w && hit(paddr_i, `ACCR_IDX_CHAN0_OFFH)), // [RULE5]
    .wr_data_i (wdata_w),
    .value_o   (offh_w)
  );
  accr_word_reg #(.RST_VAL(`ACCR_RST_OFFSET), .WMASK(`ACCR_LOW_WMASK)) u_offl (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .wr_en_i   (wr_go_w && hit(paddr_i, `ACCR_IDX_CHAN0_OFFL)), // [RULE6]
    .wr_data_i (wdata_w),
    .value_o   (offl_w)
  );
  accr_word_reg #(.RST_VAL(`ACCR_RST_GAIN_HIGH), .WMASK(16'hffff)) u_gainh (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .wr_en_i   (wr_go_w && hit(paddr_i, `ACCR_IDX_CHAN0_GAINH)), // [RULE7] [RULE8]
    .wr_data_i (wdata_w),
    .value_o   (gainh_w)
  );
  accr_word_reg #(.RST_VAL(`ACCR_RST_GAIN_LOW), .WMASK(`ACCR_LOW_WMASK)) u_gainl (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .wr_en_i   (wr_go_w && hit(paddr_i, `ACCR_IDX_CHAN0_GAINL)), // [RULE7]
    .wr_data_i (wdata_w),
    .value_o   (gainl_w)
  );
  accr_word_reg #(.RST_VAL(`ACCR_RST_CONFIG), .WMASK(`ACCR_CFG_WMASK)) u_cfg1 (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .wr_en_i   (wr_go_w && hit(paddr_i, `ACCR_IDX_CHAN1_CONFIG)), // [RULE2]
    .wr_data_i (wdata_w),
    .value_o   (cfg1_w)
  );

  // Both words joined so a half-written value is still used whole
  accr_sample_corr u_corr (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .valid_i   (sample_valid_i),
    .sample_i  (sample_i),
    .offset_i  ({offh_w, offl_w[15:8]}),   // [RULE10] [RULE5] [RULE6]
    .gain_i    ({gainh_w, gainl_w[15:8]}), // [RULE10] [RULE7]
    .valid_o   (corr_valid_w),
    .sample_o  (corr_sample_w)
  );

  // Read mux; reserved bits come back as zero from the masked words
  reg [15:0] rd_next;
  reg        map_next;
  always @* begin
    rd_next  = 16'h0000;
    map_next = 1'b1;
    if (hit(paddr_i, `ACCR_IDX_THRESH_LOW))
      rd_next = thr_w;
    else if (hit(paddr_i, `ACCR_IDX_CHAN0_CONFIG))
      rd_next = cfg0_w;                  // [RULE2]
    else if (hit(paddr_i, `ACCR_IDX_CHAN0_OFFH))
      rd_next = offh_w;
    else if (hit(paddr_i, `ACCR_IDX_CHAN0_OFFL))
      rd_next = offl_w;                  // [RULE6]
    else if (hit(paddr_i, `ACCR_IDX_CHAN0_GAINH))
      rd_next = gainh_w;
    else if (hit(paddr_i, `ACCR_IDX_CHAN0_GAINL))
      rd_next = gainl_w;
    else if (hit(paddr_i, `ACCR_IDX_CHAN1_CONFIG))
      rd_next = cfg1_w;
    else
      map_next = 1'b0;
  end

  // APB answer: no wait state, pready rises in the first access cycle
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h00000000;
      pslverr_o <= 1'b0;
    end else if (setup_w) begin
      pready_o  <= 1'b1;
      prdata_o  <= pwrite_i ? 32'h00000000 : {16'h0000, rd_next};
      pslverr_o <= !map_next || (pwrite_i && (pstrb_i[1:0] != 2'h3));
    end else begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  // Channel controls registered so every output comes from a flip-flop
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      chan0_phase_delay_o      <= 10'h000;
      chan0_highpass_bypass_o  <= 1'b0;
      chan0_input_select_o     <= `ACCR_SEL_OWN_PINS;
      chan0_highpass_setting_o <= 4'h0;
      chan0_highpass_active_o  <= 1'b0;
      chan1_phase_delay_o      <= 10'h000;
      chan1_input_select_o     <= `ACCR_SEL_OWN_PINS;
      chan1_highpass_setting_o <= 4'h0;
      chan1_highpass_active_o  <= 1'b0;
      sample_valid_o           <= 1'b0;
      sample_o                 <= 24'h000000;
    end else begin
      chan0_phase_delay_o     <= cfg0_w[`ACCR_CFG_PHASE_HI:`ACCR_CFG_PHASE_LO]; // [RULE1]
      chan0_highpass_bypass_o <= cfg0_w[`ACCR_CFG_BYPASS_BIT];                   // [RULE3]
      chan0_input_select_o    <= cfg0_w[1:0];                                    // [RULE4]
      // Bypass forces setting to zero (filter off) for this channel only
      chan0_highpass_setting_o <= cfg0_w[`ACCR_CFG_BYPASS_BIT] ? 4'h0 : thr_w[3:0]; // [RULE9] [RULE3]
      chan0_highpass_active_o  <= !cfg0_w[`ACCR_CFG_BYPASS_BIT] && (thr_w[3:0] != 4'h0); // [RULE9]
      chan1_phase_delay_o      <= cfg1_w[`ACCR_CFG_PHASE_HI:`ACCR_CFG_PHASE_LO]; // [RULE1]
      chan1_input_select_o     <= cfg1_w[1:0];                                    // [RULE4]
      chan1_highpass_setting_o <= cfg1_w[`ACCR_CFG_BYPASS_BIT] ? 4'h0 : thr_w[3:0]; // [RULE9] [RULE3]
      chan1_highpass_active_o  <= !cfg1_w[`ACCR_CFG_BYPASS_BIT] && (thr_w[3:0] != 4'h0); // [RULE9]
      sample_valid_o           <= corr_valid_w;
      sample_o                 <= corr_sample_w;
    end
  end
endmodule // accr_chan_regs

// [accr_chan_regs_assertions.sv]
// Checker for the channel calibration register group
`timescale 1ns/1ps
module accr_chan_regs_chk (
  input wire        clk_sys_i, sys_rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o,
  input wire        sample_valid_i, sample_valid_o, chan0_highpass_bypass_o, chan0_highpass_active_o,
  input wire [31:0] paddr_i, pwdata_i, prdata_o,
  input wire [3:0]  pstrb_i, chan0_highpass_setting_o,
  input wire [9:0]  chan0_phase_delay_o,
  input wire [1:0]  chan0_input_select_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // Accepted write to the channel 0 config word, and any read answer
  wire cfg_wr = psel_i && !penable_i && pwrite_i && pstrb_i[1:0] == 2'h3 && paddr_i == 32'h24;
  wire rd_ack = pready_o && !pwrite_i;
  // Control outputs lag the stored word by one cycle
  a_phase_follows_write:
    assert property (cfg_wr |=> ##1 chan0_phase_delay_o == $past(pwdata_i[15:6], 2)) else $error("phase delay wrong");
  a_select_follows_write:
    assert property (cfg_wr |=> ##1 chan0_input_select_o == $past(pwdata_i[1:0], 2)) else $error("input select wrong");
  a_cfg_reserved_zero:
    assert property (rd_ack && paddr_i == 32'h24 |-> prdata_o[5:3] == 3'h0) else $error("config reserved set");
  a_offl_low_zero:
    assert property (rd_ack && paddr_i == 32'h2c |-> prdata_o[7:0] == 8'h00) else $error("offset low byte set");
  a_gainl_low_zero:
    assert property (rd_ack && paddr_i == 32'h34 |-> prdata_o[7:0] == 8'h00) else $error("gain low byte set");
  a_bypass_masks_hp:
    assert property (chan0_highpass_bypass_o |-> chan0_highpass_setting_o == 4'h0 && !chan0_highpass_active_o)
      else $error("bypass ignored");
  a_active_needs_setting:
    assert property (chan0_highpass_active_o == (chan0_highpass_setting_o != 4'h0)) else $error("active flag wrong");
  a_sample_latency:
    assert property (sample_valid_i |-> ##3 sample_valid_o) else $error("sample strobe late");
  c_cfg_write: cover property (cfg_wr);
  c_refused: cover property (pready_o && pslverr_o);
  c_sample: cover property (sample_valid_o);
endmodule // accr_chan_regs_chk

bind accr_chan_regs accr_chan_regs_chk accr_chan_regs_chk_i (.*);

// [accr_chan_regs_tb.sv]
// Self-checking bench for the channel calibration register group
`timescale 1ns/1ps
`include "accr_map.vh"
module accr_chan_regs_tb;
  reg         clk_sys_i = 1'b0, sys_rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  reg         sample_valid_i = 1'b0;
  reg  [31:0] paddr_i = 32'h0, pwdata_i = 32'h0, rd;
  reg  [3:0]  pstrb_i = 4'hf;
  reg  [23:0] sample_i = 24'h0;
  reg         er;
  wire        pready_o, pslverr_o, sample_valid_o, bp0, act0, act1;
  wire [31:0] prdata_o;
  wire [23:0] sample_o;
  wire [9:0]  ph0, ph1;
  wire [1:0]  sel0, sel1;
  wire [3:0]  hp0, hp1;
  integer     failures = 0, compares = 0, i;
  always #5 clk_sys_i = ~clk_sys_i;
  accr_chan_regs accr_chan_regs_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o), .sample_valid_i(sample_valid_i),
    .sample_i(sample_i), .sample_valid_o(sample_valid_o), .sample_o(sample_o), .chan0_phase_delay_o(ph0),
    .chan0_highpass_bypass_o(bp0), .chan0_input_select_o(sel0), .chan0_highpass_setting_o(hp0),
    .chan0_highpass_active_o(act0), .chan1_phase_delay_o(ph1), .chan1_input_select_o(sel1),
    .chan1_highpass_setting_o(hp1), .chan1_highpass_active_o(act1));
  task check(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task complete_run;
    begin
      $display("Counts: %0d compares, %0d failures", compares, failures);
      if (failures == 0 && compares > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // Bounded wait; a hang counts as a mismatch and ends the run
  task wait_for(input integer n);
    if (n >= 16) begin
      failures = failures + 1;
      $display("Error at %0t: wait timed out", $time);
      complete_run;
    end
  endtask
  // One APB transfer; request held until pready is seen at an edge
  task apb(input w, input [31:0] a, input [31:0] d, input [3:0] s);
    integer n;
    begin
      @(posedge clk_sys_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      pstrb_i <= s;
      @(posedge clk_sys_i);
      penable_i <= 1'b1;
      n = 0;
      @(posedge clk_sys_i);
      while (pready_o !== 1'b1 && n < 16) begin
        @(posedge clk_sys_i);
        n = n + 1;
      end
      wait_for(n);
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
    end
  endtask
  task samp(input [23:0] s, input [23:0] e);
    integer n;
    begin
      @(posedge clk_sys_i);
      sample_valid_i <= 1'b1;
      sample_i <= s;
      @(posedge clk_sys_i);
      sample_valid_i <= 1'b0;
      n = 0;
      while (sample_valid_o !== 1'b1 && n < 16) begin
        @(posedge clk_sys_i);
        n = n + 1;
      end
      wait_for(n);
      check(sample_o, e);
    end
  endtask
  task t_reset;
    for (i = 0; i < 7; i = i + 1) begin
      apb(1'b0, 32'h20 + 4 * i, 32'h0, 4'h0);
      check(rd, (i == 4) ? 32'h8000 : 32'h0);
    end
  endtask
  task t_cfg;
    begin
      apb(1'b1, 32'h24, 32'hffff, 4'hf);
      apb(1'b0, 32'h24, 32'h0, 4'h0);
      check(rd, 32'hffc7);
      check(bp0, 1'b1);
      // Every selector code with a negative phase count
      for (i = 0; i < 4; i = i + 1) begin
        apb(1'b1, 32'h24, {16'h0, 10'h200 + i[9:0], 4'h0, i[1:0]}, 4'hf);
        @(posedge clk_sys_i);
        check(ph0, 10'h200 + i);
        check(sel0, i[1:0]);
      end
    end
  endtask
  task t_corr;
    begin
      apb(1'b1, 32'h28, 32'hffff, 4'hf);
      apb(1'b1, 32'h2c, 32'hffff, 4'hf);
      apb(1'b1, 32'h34, 32'hffff, 4'hf);
      apb(1'b0, 32'h28, 32'h0, 4'h0);
      check(rd, 32'hffff);
      apb(1'b0, 32'h2c, 32'h0, 4'h0);
      check(rd, 32'hff00);
      apb(1'b0, 32'h34, 32'h0, 4'h0);
      check(rd, 32'hff00);
      // Offset of -1 at unity gain, low gain byte cleared
      apb(1'b1, 32'h34, 32'h0, 4'hf);
      samp(24'hffff9c, 24'hffff9b);
      // Offset 10h at half gain
      apb(1'b1, 32'h28, 32'h0, 4'hf);
      apb(1'b1, 32'h2c, 32'h1000, 4'hf);
      apb(1'b1, 32'h30, 32'h4000, 4'hf);
      samp(24'h000064, 24'h00003a);
    end
  endtask
  task t_hp;
    begin
      apb(1'b1, 32'h24, 32'h0, 4'hf);
      apb(1'b1, 32'h20, 32'h00f5, 4'hf);
      @(posedge clk_sys_i);
      check({hp0, act0, hp1, act1}, {4'h5, 1'b1, 4'h5, 1'b1});
      apb(1'b1, 32'h24, 32'h4, 4'hf);
      @(posedge clk_sys_i);
      check({hp0, act0, hp1}, {4'h0, 1'b0, 4'h5});
      // Unmapped word and a refused narrow write
      apb(1'b0, 32'h40, 32'h0, 4'h0);
      check(er, 1'b1);
      check(rd, 32'h0);
      apb(1'b1, 32'h24, 32'h3, 4'h1);
      check(er, 1'b1);
      apb(1'b0, 32'h24, 32'h0, 4'h0);
      check(rd, 32'h4);
      // Channel 1 word: phase 155h, bypass set, positive test level
      apb(1'b1, 32'h38, 32'h5546, 4'hf);
      @(posedge clk_sys_i);
      check(ph1, 10'h155);
      check(sel1, `ACCR_SEL_TEST_POS);
      check({hp1, act1}, {4'h0, 1'b0});
      apb(1'b0, 32'h38, 32'h0, 4'h0);
      check(rd, 32'h5546);
    end
  endtask
  initial begin
    repeat (16) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    t_reset;
    t_cfg;
    t_corr;
    t_hp;
    complete_run;
  end
endmodule // accr_chan_regs_tb
